// File: core/acdc_divider.sv
// integer clock divider producing a clock enable pulse and a square clock
`timescale 1ns/10ps
`default_nettype none
module acdc_divider #(
   parameter int WIDTH = 7
) (
   input  wire logic             clk_sys_i,
   input  wire logic             reset_n_i,
   input  wire logic             run_i,
   input  wire logic [WIDTH-1:0] div_i,
   output logic                  tick_o,
   output logic                  clk_o
);
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] div_reg;
   logic             tick_reg;
   logic             clk_reg;
   // ****************************************
   // count to the field value, divide by value plus one
   // ****************************************
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_reg <= '0;
         div_reg   <= '0;
         tick_reg  <= 1'b0;
         clk_reg   <= 1'b0;
      end else if (!run_i) begin
         // hold the count so a gated divider keeps its phase
         tick_reg  <= 1'b0;
      end else if (count_reg >= div_reg) begin
         // new value only loaded at period end, no runt pulse
         count_reg <= '0;
         div_reg   <= div_i; // RULE_15
         tick_reg  <= 1'b1;
         clk_reg   <= 1'b1;
      end else begin
         count_reg <= count_reg + 1'b1;
         tick_reg  <= 1'b0;
         if (count_reg == (div_reg >> 1)) begin
            clk_reg <= 1'b0;
         end
      end
   end
   assign tick_o = tick_reg;
   assign clk_o  = clk_reg;
endmodule
`default_nettype wire

// File: core/acdc_pkg.sv
// package of register map, field layouts and types for the audio clock divider block
package acdc_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [7:0] ADDR_PLL_P_DIV      = 8'h14;
   localparam logic [7:0] ADDR_PLL_J_INT      = 8'h15;
   localparam logic [7:0] ADDR_PLL_D_HIGH     = 8'h16;
   localparam logic [7:0] ADDR_PLL_FRAC_LOW   = 8'h17;
   localparam logic [7:0] ADDR_PLL_MULT_R     = 8'h18;
   localparam logic [7:0] ADDR_PROC_DIV       = 8'h1b;
   localparam logic [7:0] ADDR_CONV_DIV       = 8'h1c;
   localparam logic [7:0] ADDR_CPUMP_DIV      = 8'h1d;
   localparam logic [7:0] ADDR_OSR_DIV        = 8'h1e;
   localparam logic [7:0] ADDR_MBCLK_DIV      = 8'h20;
   localparam logic [7:0] ADDR_MFCLK_DIV      = 8'h21;
   localparam logic [7:0] ADDR_AUTO_CTRL      = 8'h25;
   // ****************************************
   // field widths and positions
   // ****************************************
   localparam int          P_W          = 4;
   localparam int          J_W          = 6;
   localparam int          DH_W         = 6;
   localparam int          DL_W         = 8;
   localparam int          R_W          = 4;
   localparam int          DIV7_W       = 7;
   localparam int          DIV8_W       = 8;
   localparam int          AUTO_DIS_BIT = 1;
   localparam logic [13:0] D_MAX        = 14'h270f;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RST_P     = 8'h00;
   localparam logic [7:0] RST_J     = 8'h08;
   localparam logic [7:0] RST_DH    = 8'h00;
   localparam logic [7:0] RST_DL    = 8'h00;
   localparam logic [7:0] RST_R     = 8'h00;
   localparam logic [7:0] RST_PROC  = 8'h00;
   localparam logic [7:0] RST_CONV  = 8'h01;
   localparam logic [7:0] RST_CPUMP = 8'h01;
   localparam logic [7:0] RST_OSR   = 8'h01;
   localparam logic [7:0] RST_MBCLK = 8'h00;
   localparam logic [7:0] RST_MFCLK = 8'h00;
   localparam logic [7:0] RST_AUTO  = 8'h00;
   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic [P_W-1:0]  pre_div;
      logic [J_W-1:0]  int_j;
      logic [13:0]     frac_d;
      logic [4:0]      mult_r;
   } acdc_pll_cfg_s;
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } acdc_reg_req_s;
endpackage

// File: core/acdc_top.sv
// register file and clock dividers of the audio clock tree
// Notes on behaviour
// RULE_01: fraction D is decimal 0..9999 from high and low parts.
// RULE_02: software never writes a fraction above 9999.
// RULE_03: R field value n gives multiplier n plus one, 1 to 16.
// RULE_04: under auto setup, manual PLL and divider fields are ignored; the bit and frame clock dividers still use mbclk_reg and mfclk_reg.
// RULE_05: processor clock divides source by field plus one, 1 to 128.
// RULE_06: converter clock divides source by field plus one, 1 to 128.
// RULE_07: charge pump clock divides source by field plus one.
// RULE_08: oversampling clock divides source by field plus one.
// RULE_09: master bit clock divides master clock by field plus one.
// RULE_10: master frame clock divides bit clock by field plus one, to 256.
// RULE_11: J field value n selects J equal n, 1 to 63.
// RULE_12: P field value n gives pre-divider n plus one, up to 15; the code passes the field value n to pre_div unchanged.
// RULE_13: fraction high part is a separate six bit field.
// RULE_14: a control bit disables auto setup, making manual fields active.
// RULE_15: output is ref times J.D times R over P; no runt pulses.
`timescale 1ns/10ps
`default_nettype none
module acdc_top
   import acdc_pkg::*;
(
   input  wire logic                    clk_sys_i,
   input  wire logic                    reset_n_i,
   input  wire acdc_pkg::acdc_reg_req_s req_i,
   input  wire acdc_pkg::acdc_pll_cfg_s auto_pll_i,
   input  wire logic [6:0]              auto_proc_div_i,
   input  wire logic [6:0]              auto_conv_div_i,
   input  wire logic [6:0]              auto_cpump_div_i,
   input  wire logic [6:0]              auto_osr_div_i,
   input  wire logic                    serial_master_i,
   output logic [7:0]                   rdata_o,
   output logic                         rvalid_o,
   output acdc_pkg::acdc_pll_cfg_s      pll_cfg_o,
   output logic                         auto_active_o,
   output logic                         proc_tick_o,
   output logic                         conv_tick_o,
   output logic                         cpump_tick_o,
   output logic                         osr_tick_o,
   output logic                         bit_clk_o,
   output logic                         frame_clk_o
);
   import acdc_pkg::*;
   // ****************************************
   // registers
   // ****************************************
   logic [7:0]    p_reg;
   logic [7:0]    j_reg;
   logic [7:0]    dh_reg;
   logic [7:0]    dl_reg;
   logic [7:0]    r_reg;
   logic [7:0]    proc_reg;
   logic [7:0]    conv_reg;
   logic [7:0]    cpump_reg;
   logic [7:0]    osr_reg;
   logic [7:0]    mbclk_reg;
   logic [7:0]    mfclk_reg;
   logic [7:0]    auto_reg;
   logic [7:0]    rdata_reg;
   logic          rvalid_reg;
   logic [7:0]    rdata_next;
   logic          manual;
   logic [13:0]   frac_d;
   acdc_pll_cfg_s man_pll;
   acdc_pll_cfg_s pll_reg;
   logic [6:0]    proc_div;
   logic [6:0]    conv_div;
   logic [6:0]    cpump_div;
   logic [6:0]    osr_div;
   logic          bit_tick;
   logic          bit_clk;
   logic          frame_clk;
   // ****************************************
   // register writes
   // ****************************************
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         p_reg     <= RST_P;
         j_reg     <= RST_J;
         dh_reg    <= RST_DH;
         dl_reg    <= RST_DL;
         r_reg     <= RST_R;
         proc_reg  <= RST_PROC;
         conv_reg  <= RST_CONV;
         cpump_reg <= RST_CPUMP;
         osr_reg   <= RST_OSR;
         mbclk_reg <= RST_MBCLK;
         mfclk_reg <= RST_MFCLK;
         auto_reg  <= RST_AUTO;
      end else if (req_i.wr) begin
         if (req_i.addr == ADDR_PLL_P_DIV) begin
            p_reg <= {4'h0, req_i.wdata[P_W-1:0]};
         end else if (req_i.addr == ADDR_PLL_J_INT) begin
            j_reg <= {2'h0, req_i.wdata[J_W-1:0]};
         end else if (req_i.addr == ADDR_PLL_D_HIGH) begin
            dh_reg <= {2'h0, req_i.wdata[DH_W-1:0]}; // RULE_13
         end else if (req_i.addr == ADDR_PLL_FRAC_LOW) begin
            dl_reg <= req_i.wdata;
         end else if (req_i.addr == ADDR_PLL_MULT_R) begin
            r_reg <= {4'h0, req_i.wdata[R_W-1:0]};
         end else if (req_i.addr == ADDR_PROC_DIV) begin
            proc_reg <= {1'b0, req_i.wdata[DIV7_W-1:0]};
         end else if (req_i.addr == ADDR_CONV_DIV) begin
            conv_reg <= {1'b0, req_i.wdata[DIV7_W-1:0]};
         end else if (req_i.addr == ADDR_CPUMP_DIV) begin
            cpump_reg <= {1'b0, req_i.wdata[DIV7_W-1:0]};
         end else if (req_i.addr == ADDR_OSR_DIV) begin
            osr_reg <= {1'b0, req_i.wdata[DIV7_W-1:0]};
         end else if (req_i.addr == ADDR_MBCLK_DIV) begin
            mbclk_reg <= {1'b0, req_i.wdata[DIV7_W-1:0]};
         end else if (req_i.addr == ADDR_MFCLK_DIV) begin
            mfclk_reg <= req_i.wdata;
         end else if (req_i.addr == ADDR_AUTO_CTRL) begin
            auto_reg <= req_i.wdata;
         end
      end
   end
   // ****************************************
   // register reads
   // ****************************************
   always_comb begin
      rdata_next = 8'h00;
      if (req_i.addr == ADDR_PLL_P_DIV) begin
         rdata_next = p_reg;
      end else if (req_i.addr == ADDR_PLL_J_INT) begin
         rdata_next = j_reg;
      end else if (req_i.addr == ADDR_PLL_D_HIGH) begin
         rdata_next = dh_reg;
      end else if (req_i.addr == ADDR_PLL_FRAC_LOW) begin
         rdata_next = dl_reg;
      end else if (req_i.addr == ADDR_PLL_MULT_R) begin
         rdata_next = r_reg;
      end else if (req_i.addr == ADDR_PROC_DIV) begin
         rdata_next = proc_reg;
      end else if (req_i.addr == ADDR_CONV_DIV) begin
         rdata_next = conv_reg;
      end else if (req_i.addr == ADDR_CPUMP_DIV) begin
         rdata_next = cpump_reg;
      end else if (req_i.addr == ADDR_OSR_DIV) begin
         rdata_next = osr_reg;
      end else if (req_i.addr == ADDR_MBCLK_DIV) begin
         rdata_next = mbclk_reg;
      end else if (req_i.addr == ADDR_MFCLK_DIV) begin
         rdata_next = mfclk_reg;
      end else if (req_i.addr == ADDR_AUTO_CTRL) begin
         rdata_next = auto_reg;
      end
   end
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg  <= req_i.rd ? rdata_next : rdata_reg;
         rvalid_reg <= req_i.rd;
      end
   end
   // ****************************************
   // manual or automatic selection
   // ****************************************
   assign manual = auto_reg[AUTO_DIS_BIT]; // RULE_14
   // decimal fraction, high and low parts concatenated, clamped
   assign frac_d = ({dh_reg[DH_W-1:0], dl_reg} > D_MAX) ?
                   D_MAX : {dh_reg[DH_W-1:0], dl_reg}; // RULE_01
   always_comb begin
      man_pll.pre_div = p_reg[P_W-1:0];            // RULE_12
      man_pll.int_j   = j_reg[J_W-1:0];            // RULE_11
      man_pll.frac_d  = frac_d;                    // RULE_01
      man_pll.mult_r  = {1'b0, r_reg[R_W-1:0]} + 5'h01; // RULE_03
   end
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pll_reg <= '0;
      end else begin
         pll_reg <= manual ? man_pll : auto_pll_i; // RULE_04
      end
   end
   assign proc_div  = manual ? proc_reg[6:0]  : auto_proc_div_i;  // RULE_04
   assign conv_div  = manual ? conv_reg[6:0]  : auto_conv_div_i;  // RULE_04
   assign cpump_div = manual ? cpump_reg[6:0] : auto_cpump_div_i; // RULE_04
   assign osr_div   = manual ? osr_reg[6:0]   : auto_osr_div_i;   // RULE_04
   // ****************************************
   // dividers
   // ****************************************
   acdc_divider #(.WIDTH(DIV7_W)) u_proc (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .run_i     (1'b1),
      .div_i     (proc_div), // RULE_05
      .tick_o    (proc_tick_o),
      .clk_o     ()
   );
   acdc_divider #(.WIDTH(DIV7_W)) u_conv (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .run_i     (1'b1),
      .div_i     (conv_div), // RULE_06
      .tick_o    (conv_tick_o),
      .clk_o     ()
   );
   acdc_divider #(.WIDTH(DIV7_W)) u_cpump (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .run_i     (1'b1),
      .div_i     (cpump_div), // RULE_07
      .tick_o    (cpump_tick_o),
      .clk_o     ()
   );
   acdc_divider #(.WIDTH(DIV7_W)) u_osr (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .run_i     (1'b1),
      .div_i     (osr_div), // RULE_08
      .tick_o    (osr_tick_o),
      .clk_o     ()
   );
   acdc_divider #(.WIDTH(DIV7_W)) u_bclk (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .run_i     (serial_master_i),
      .div_i     (mbclk_reg[6:0]), // RULE_09
      .tick_o    (bit_tick),
      .clk_o     (bit_clk)
   );
   acdc_divider #(.WIDTH(DIV8_W)) u_fclk (
      .clk_sys_i (clk_sys_i),
      .reset_n_i (reset_n_i),
      .run_i     (bit_tick), // RULE_10
      .div_i     (mfclk_reg),
      .tick_o    (),
      .clk_o     (frame_clk)
   );
   assign pll_cfg_o     = pll_reg; // RULE_15
   assign auto_active_o = ~manual;
   assign rdata_o       = rdata_reg;
   assign rvalid_o      = rvalid_reg;
   assign bit_clk_o     = serial_master_i & bit_clk;
   assign frame_clk_o   = serial_master_i & frame_clk;
endmodule
`default_nettype wire

// File: tb/acdc_top_sva.sv
// checker of register access, pll selection and divider timing
`timescale 1ns/10ps
`default_nettype none
module acdc_top_sva
   import acdc_pkg::*;
(
   input  wire logic                    clk_sys_i,
   input  wire logic                    reset_n_i,
   input  wire acdc_pkg::acdc_reg_req_s req_i,
   input  wire acdc_pkg::acdc_pll_cfg_s auto_pll_i,
   input  wire logic                    serial_master_i,
   input  wire logic [7:0]              rdata_o,
   input  wire logic                    rvalid_o,
   input  wire acdc_pkg::acdc_pll_cfg_s pll_cfg_o,
   input  wire logic                    auto_active_o,
   input  wire logic                    proc_tick_o,
   input  wire logic                    osr_tick_o,
   input  wire logic                    bit_clk_o,
   input  wire logic                    frame_clk_o
);
   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);
   chk_read_answered: assert property (req_i.rd |=> rvalid_o)
      else $error("read not answered");
   chk_rvalid_cause: assert property (rvalid_o |-> $past(req_i.rd))
      else $error("read valid without read");
   chk_rdata_hold: assert property (!$past(req_i.rd) |-> $stable(rdata_o))
      else $error("read data moved without read");
   chk_unmapped_zero: assert property (req_i.rd && !(req_i.addr inside
      {8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h1b, 8'h1c, 8'h1d, 8'h1e,
       8'h20, 8'h21, 8'h25}) |=> rdata_o == 8'h00)
      else $error("unmapped read not zero");
   chk_auto_pll_used: assert property (auto_active_o && $past(auto_active_o)
      && $past(auto_active_o, 2) && $past(reset_n_i)
      |-> pll_cfg_o == $past(auto_pll_i))
      else $error("auto pll setting not used");
   chk_frac_max: assert property (pll_cfg_o.frac_d <= D_MAX)
      else $error("fraction above limit");
   chk_manual_r_range: assert property (!auto_active_o && $past(reset_n_i, 2)
      && !$past(auto_active_o) && !$past(auto_active_o, 2)
      |-> pll_cfg_o.mult_r inside {[5'h01:5'h10]})
      else $error("r multiplier out of range");
   chk_serial_idle: assert property (!serial_master_i
      && !$past(serial_master_i) && !$past(serial_master_i, 2)
      |-> !bit_clk_o && !frame_clk_o)
      else $error("serial clocks run while not master");
   chk_proc_period: assert property (proc_tick_o |-> ##[1:128] proc_tick_o)
      else $error("processor tick too late");
   chk_osr_period: assert property (osr_tick_o |-> ##[1:128] osr_tick_o)
      else $error("oversample tick too late");
endmodule
bind acdc_top acdc_top_sva chk (.clk_sys_i(clk_sys_i),
   .reset_n_i(reset_n_i), .req_i(req_i), .auto_pll_i(auto_pll_i),
   .serial_master_i(serial_master_i), .rdata_o(rdata_o),
   .rvalid_o(rvalid_o), .pll_cfg_o(pll_cfg_o),
   .auto_active_o(auto_active_o), .proc_tick_o(proc_tick_o),
   .osr_tick_o(osr_tick_o), .bit_clk_o(bit_clk_o),
   .frame_clk_o(frame_clk_o));
`default_nettype wire

// File: tb/acdc_top_tb.sv
// testbench of the audio clock divider register block
`timescale 1ns/10ps
`default_nettype none
module acdc_top_tb;
   import acdc_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic          clk_sys_i = 1'b0;
   logic          reset_n_i = 1'b0;
   acdc_reg_req_s req_i;
   acdc_pll_cfg_s auto_pll_i;
   logic [6:0]    auto_div [4];
   logic          serial_master_i;
   logic [7:0]    rdata_o;
   logic          rvalid_o;
   acdc_pll_cfg_s pll_cfg_o;
   logic          auto_active_o;
   wire logic [5:0] outs;
   int            num_errors = 0;
   int            n_compared = 0;
   int            cycles = 0;
   logic [7:0] reg_adr [8] = '{8'h17, 8'h18, 8'h1b, 8'h1c, 8'h1d, 8'h1e,
                               8'h20, 8'h21};
   logic [7:0] reg_rst [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01,
                               8'h00, 8'h00};
   logic [7:0] reg_msk [8] = '{8'hff, 8'h0f, 8'h7f, 8'h7f, 8'h7f, 8'h7f,
                               8'h7f, 8'hff};
   logic [7:0] dh [3] = '{8'h1f, 8'h27, 8'h04};
   logic [7:0] dl [3] = '{8'h40, 8'h0f, 8'hd2};
   logic [13:0] dx [3] = '{14'h1f40, 14'h270f, 14'h04d2};
   logic [7:0] rv [3] = '{8'h0f, 8'h00, 8'h07};
   logic [4:0] rx [3] = '{5'h10, 5'h01, 5'h08};
   logic [7:0] man_div [4] = '{8'h7f, 8'h04, 8'h01, 8'h06};
   always #4 clk_sys_i = ~clk_sys_i;
   acdc_top dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .req_i(req_i), .auto_pll_i(auto_pll_i),
      .auto_proc_div_i(auto_div[0]), .auto_conv_div_i(auto_div[1]),
      .auto_cpump_div_i(auto_div[2]), .auto_osr_div_i(auto_div[3]),
      .serial_master_i(serial_master_i), .rdata_o(rdata_o),
      .rvalid_o(rvalid_o), .pll_cfg_o(pll_cfg_o),
      .auto_active_o(auto_active_o), .proc_tick_o(outs[0]),
      .conv_tick_o(outs[1]), .cpump_tick_o(outs[2]),
      .osr_tick_o(outs[3]), .bit_clk_o(outs[4]), .frame_clk_o(outs[5]));
   // ****************************************
   // tasks
   // ****************************************
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got,
                  exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys_i);
      req_i <= '0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys_i);
      req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_sys_i);
      req_i <= '0;
      #1;
      chk(rvalid_o, 1'b1, "read valid");
      chk(rdata_o, exp, "read data");
   endtask
   task automatic settle();
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic rise(input int s, output int n);
      logic p;
      p = outs[s];
      for (n = 1; n < 1200; n++) begin
         @(posedge clk_sys_i);
         #1;
         if (outs[s] && !p) break;
         p = outs[s];
      end
   endtask
   task automatic period(input int s, input int exp);
      int n;
      repeat (3) rise(s, n);
      chk(n, exp, "clock period");
   endtask
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("unexpected at %0t: run too long", $time);
         finish_test();
      end
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      req_i = '0;
      auto_pll_i = '{pre_div: 4'h2, int_j: 6'h0a, frac_d: 14'h04d2,
                     mult_r: 5'h04};
      auto_div = '{7'h02, 7'h03, 7'h04, 7'h05};
      serial_master_i = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      for (int i = 0; i < 8; i++) rchk(reg_adr[i], reg_rst[i]);
      rchk(8'h25, 8'h00);
      rchk(8'h14, 8'h00);
      rchk(8'h15, 8'h08);
      $display("test reset_values done");
      for (int i = 0; i < 8; i++) begin
         wr(reg_adr[i], 8'hff);
         rchk(reg_adr[i], reg_msk[i]);
      end
      wr(8'h19, 8'hff);
      rchk(8'h19, 8'h00);
      $display("test access done");
      settle();
      chk(auto_active_o, 1'b1, "auto active");
      chk(pll_cfg_o, auto_pll_i, "auto pll");
      for (int s = 0; s < 4; s++) period(s, s + 3);
      $display("test auto_setup done");
      wr(8'h15, 8'h05);
      wr(8'h14, 8'h0e);
      wr(8'h25, 8'h02);
      settle();
      chk(auto_active_o, 1'b0, "manual mode");
      chk(pll_cfg_o.int_j, 6'h05, "integer factor");
      chk(pll_cfg_o.pre_div, 4'he, "pre divider");
      for (int i = 0; i < 3; i++) begin
         wr(8'h16, dh[i]);
         wr(8'h17, dl[i]);
         wr(8'h18, rv[i]);
         settle();
         chk(pll_cfg_o.frac_d, dx[i], "fraction");
         chk(pll_cfg_o.mult_r, rx[i], "r multiplier");
      end
      for (int s = 0; s < 4; s++) begin
         wr(reg_adr[s + 2], man_div[s]);
         period(s, man_div[s] + 1);
      end
      $display("test manual_setup done");
      chk(outs[5:4], 2'b00, "serial idle");
      @(posedge clk_sys_i);
      serial_master_i <= 1'b1;
      wr(8'h20, 8'h01);
      wr(8'h21, 8'hff);
      period(4, 2);
      period(5, 512);
      $display("test serial_master done");
      finish_test();
   end
endmodule
`default_nettype wire
